// [core/sbct_cfg.svh]
// Constants of the sixteen-bit counter/timer: addresses, fields, reset values
`ifndef SBCT_CFG_SVH
`define SBCT_CFG_SVH

// Register-select addresses
`define SBCT_RS_ACR 4'h4
`define SBCT_RS_ISR 4'h5
`define SBCT_RS_UPPER 4'h6
`define SBCT_RS_LOWER 4'h7
`define SBCT_RS_START 4'hE
`define SBCT_RS_STOP 4'hF

// Field positions
`define SBCT_ISR_RDY_BIT 3
`define SBCT_ACR_SRC_HI 6
`define SBCT_ACR_SRC_LO 4

// Reset values
`define SBCT_ACR_RESET 3'h6
`define SBCT_PRELOAD_RESET 16'h0001
`define SBCT_COUNT_RESET 16'h0000

// Prescaler: divide by sixteen
`define SBCT_DIV_LAST 4'hF

`endif

// [core/sbct_div16.sv]
// Divide-by-sixteen prescaler on a stream of tick pulses
`include "sbct_cfg.svh"
`timescale 1ns/100ps
module sbct_div16 (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Input ticks and divided ticks
  input wire logic tickIn,
  output logic tickOut
);

  logic [3:0] div_reg;
  logic [3:0] div_next;

  // Count ticks, pulse on the sixteenth
  always_comb
  begin
    div_next = div_reg;
    if (tickIn)
    begin
      div_next = div_reg + 4'h1;
    end
  end

  assign tickOut = tickIn && (div_reg == `SBCT_DIV_LAST);

  // Prescaler register
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      div_reg <= 4'h0;
    end
    else
    begin
      div_reg <= div_next;
    end
  end

endmodule

// [core/sbct_pkg.sv]
// Types shared by the counter/timer modules
package sbct_pkg;

  // One sample of the CPU bus pins
  typedef struct packed {
    logic csN;
    logic rwN;
    logic [3:0] rs;
    logic [7:0] data;
  } sbct_bus_type;

  // Clock-source field of the auxiliary control register
  typedef enum logic [2:0] {
    SRC_CNT_IP2 = 3'h0,
    SRC_CNT_TXA = 3'h1,
    SRC_CNT_TXB = 3'h2,
    SRC_CNT_X16 = 3'h3,
    SRC_TMR_IP16 = 3'h4,
    SRC_TMR_IP2 = 3'h5,
    SRC_TMR_X1 = 3'h6,
    SRC_TMR_X16 = 3'h7
  } sbct_src_type;

  // Operating state, one-hot
  typedef enum logic [2:0] {
    ST_TIMER = 3'b001,
    ST_STOP = 3'b010,
    ST_COUNT = 3'b100
  } sbct_state_type;

endpackage

// [core/sbct_sync.sv]
// Two-flop synchroniser with edge detection, one lane per bit
`timescale 1ns/100ps
module sbct_sync #(
  parameter int WIDTH = 1,
  // Idle level of each pin, so no false edge follows reset
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Raw pins and synchronised result
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] syncOut,
  output logic [WIDTH-1:0] riseOut,
  output logic [WIDTH-1:0] fallOut
);

  generate
    if (WIDTH < 1)
    begin : g_bad
      $error("sbct_sync: WIDTH must be at least 1");
    end
  endgenerate

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] last_reg;

  // Per-lane edge detection on the settled stage only
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_lane
      assign riseOut[i] = sync_reg[i] & ~last_reg[i];
      assign fallOut[i] = ~sync_reg[i] & last_reg[i];
    end
  endgenerate

  assign syncOut = sync_reg;

  // Synchroniser chain
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
      last_reg <= RESET_VAL;
    end
    else
    begin
      meta_reg <= pinIn;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

endmodule

// [core/sbct_top.sv]
// Sixteen-bit counter/timer with its CPU register port and pin outputs
`include "sbct_cfg.svh"
`timescale 1ns/100ps
module sbct_top #(
  parameter int CT_WIDTH = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // CPU bus pins
  input wire logic csN,
  input wire logic rwN,
  input wire logic [3:0] rs,
  input wire logic [7:0] dataIn,
  output logic [7:0] dataOut,
  output logic dataOe,
  output logic dtackN,
  // Clock source pins
  input wire logic txClkA,
  input wire logic txClkB,
  input wire logic crystalInput,
  input wire logic inputPinTwo,
  // Output routing controls from the output configuration
  input wire logic irqMask,
  input wire logic op3CtSel,
  input wire logic op3General,
  // Outputs
  output logic irqN,
  output logic outputPinThree,
  output logic baudClk,
  output logic ctReadyBit
);

  generate
    if (CT_WIDTH != 16)
    begin : g_bad
      $error("sbct_top: byte-wide count access needs CT_WIDTH of 16");
    end
  endgenerate

  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  sbct_pkg::sbct_bus_type busRaw;
  sbct_pkg::sbct_bus_type busSync;
  sbct_pkg::sbct_bus_type busFall;
  logic [3:0] clkRise;
  logic x1Div16;
  logic ip2Div16;

  assign busRaw = '{csN: csN, rwN: rwN, rs: rs, data: dataIn};

  // Chip select idles high: an access held from reset must still show a fall
  sbct_sync #(.WIDTH(14), .RESET_VAL(14'h2000)) u_busSync (
    .mclk(mclk),
    .rstn(rstn),
    .pinIn(busRaw),
    .syncOut(busSync),
    .riseOut(),
    .fallOut(busFall)
  );

  sbct_sync #(.WIDTH(4)) u_clkSync (
    .mclk(mclk),
    .rstn(rstn),
    .pinIn({inputPinTwo, crystalInput, txClkB, txClkA}),
    .syncOut(),
    .riseOut(clkRise),
    .fallOut()
  );

  sbct_div16 u_x1Div (
    .mclk(mclk),
    .rstn(rstn),
    .tickIn(clkRise[2]),
    .tickOut(x1Div16)
  );

  sbct_div16 u_ip2Div (
    .mclk(mclk),
    .rstn(rstn),
    .tickIn(clkRise[3]),
    .tickOut(ip2Div16)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  sbct_pkg::sbct_state_type state_reg, state_next;
  sbct_pkg::sbct_src_type acr_reg, acr_next;
  logic [15:0] preload_reg, preload_next;
  logic [15:0] count_reg, count_next;
  logic wave_reg, wave_next;
  logic half_reg, half_next;
  logic ready_reg, ready_next;
  logic [7:0] rdData_reg, rdData_next;
  logic oe_reg, oe_next;
  logic dtack_reg, dtack_next;
  logic irq_reg, irq_next;
  logic op3_reg, op3_next;

  logic csFall;
  logic rdAcc;
  logic wrAcc;
  logic startCmd;
  logic stopCmd;
  logic timerMode;
  logic tick;
  logic readySet;

  // Bus access decode on the settled chip-select edge
  assign csFall = busFall.csN;
  assign rdAcc = csFall & busSync.rwN;
  assign wrAcc = csFall & ~busSync.rwN;
  assign startCmd = rdAcc && (busSync.rs == `SBCT_RS_START);
  assign stopCmd = rdAcc && (busSync.rs == `SBCT_RS_STOP);
  assign timerMode = acr_reg[2];

  // Clock source selection
  always_comb
  begin
    tick = 1'b0;
    unique case (acr_reg)
      sbct_pkg::SRC_CNT_IP2: tick = clkRise[3];
      sbct_pkg::SRC_CNT_TXA: tick = clkRise[0];
      sbct_pkg::SRC_CNT_TXB: tick = clkRise[1];
      sbct_pkg::SRC_CNT_X16: tick = x1Div16;
      sbct_pkg::SRC_TMR_IP16: tick = ip2Div16;
      sbct_pkg::SRC_TMR_IP2: tick = clkRise[3];
      sbct_pkg::SRC_TMR_X1: tick = clkRise[2];
      sbct_pkg::SRC_TMR_X16: tick = x1Div16;
    endcase
  end

  // Next values of registers, counter and outputs
  always_comb
  begin
    state_next = state_reg;
    acr_next = acr_reg;
    preload_next = preload_reg;
    count_next = count_reg;
    wave_next = wave_reg;
    half_next = half_reg;
    readySet = 1'b0;
    rdData_next = rdData_reg;
    oe_next = oe_reg;
    dtack_next = dtack_reg;

    // Register writes, preload writable at any time
    if (wrAcc)
    begin
      unique case (busSync.rs)
        `SBCT_RS_ACR: acr_next = sbct_pkg::sbct_src_type'(
          busSync.data[`SBCT_ACR_SRC_HI:`SBCT_ACR_SRC_LO]);
        `SBCT_RS_UPPER: preload_next[15:8] = busSync.data;
        `SBCT_RS_LOWER: preload_next[7:0] = busSync.data;
        default: preload_next = preload_reg;
      endcase
    end

    // Mode transitions
    unique case (state_reg)
      sbct_pkg::ST_TIMER:
      begin
        if (!timerMode)
        begin
          state_next = sbct_pkg::ST_STOP;
        end
      end
      sbct_pkg::ST_STOP:
      begin
        if (timerMode)
        begin
          state_next = sbct_pkg::ST_TIMER;
        end
        else if (startCmd)
        begin
          state_next = sbct_pkg::ST_COUNT;
        end
      end
      sbct_pkg::ST_COUNT:
      begin
        if (timerMode)
        begin
          state_next = sbct_pkg::ST_TIMER;
        end
        else if (stopCmd && !startCmd)
        begin
          state_next = sbct_pkg::ST_STOP;
        end
      end
      default: state_next = sbct_pkg::ST_TIMER;
    endcase

    // Countdown
    if (state_reg == sbct_pkg::ST_TIMER)
    begin
      if (startCmd)
      begin
        count_next = preload_reg;
        wave_next = 1'b1;
        half_next = 1'b0;
      end
      else if (tick)
      begin
        if (count_reg == 16'h0001)
        begin
          count_next = preload_reg;
          wave_next = ~wave_reg;
          half_next = ~half_reg;
          readySet = half_reg;
        end
        else
        begin
          count_next = count_reg - 16'h0001;
        end
      end
    end
    else if (startCmd)
    begin
      count_next = preload_reg;
    end
    else if (state_reg == sbct_pkg::ST_COUNT && tick && !stopCmd)
    begin
      count_next = count_reg - 16'h0001;
      readySet = (count_reg == 16'h0001);
    end

    // Ready bit: a set in the same cycle beats a stop-read clear
    ready_next = (ready_reg & ~stopCmd) | readySet;

    // Read data and bus handshake
    if (rdAcc)
    begin
      unique case (busSync.rs)
        `SBCT_RS_ISR: rdData_next = 8'(ready_reg) << `SBCT_ISR_RDY_BIT;
        `SBCT_RS_UPPER: rdData_next = count_reg[15:8];
        `SBCT_RS_LOWER: rdData_next = count_reg[7:0];
        default: rdData_next = 8'h00;
      endcase
      oe_next = 1'b1;
    end
    if (csFall)
    begin
      dtack_next = 1'b1;
    end
    if (busSync.csN)
    begin
      oe_next = 1'b0;
      dtack_next = 1'b0;
    end

    // Interrupt and output pin three
    irq_next = ready_next & irqMask;
    if (op3CtSel)
    begin
      op3_next = timerMode ? wave_next : ~ready_next;
    end
    else
    begin
      op3_next = op3General;
    end
  end

  // State registers
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= sbct_pkg::ST_TIMER;
      acr_reg <= sbct_pkg::sbct_src_type'(`SBCT_ACR_RESET);
      preload_reg <= `SBCT_PRELOAD_RESET;
      count_reg <= `SBCT_COUNT_RESET;
      wave_reg <= 1'b1;
      half_reg <= 1'b0;
      ready_reg <= 1'b0;
      rdData_reg <= 8'h00;
      oe_reg <= 1'b0;
      dtack_reg <= 1'b0;
      irq_reg <= 1'b0;
      op3_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      acr_reg <= acr_next;
      preload_reg <= preload_next;
      count_reg <= count_next;
      wave_reg <= wave_next;
      half_reg <= half_next;
      ready_reg <= ready_next;
      rdData_reg <= rdData_next;
      oe_reg <= oe_next;
      dtack_reg <= dtack_next;
      irq_reg <= irq_next;
      op3_reg <= op3_next;
    end
  end

  // Outputs straight from flops
  assign dataOut = rdData_reg;
  assign dataOe = oe_reg;
  assign dtackN = ~dtack_reg;
  assign irqN = ~irq_reg;
  assign outputPinThree = op3_reg;
  assign baudClk = wave_reg;
  assign ctReadyBit = ready_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  preload_write_a: assert property (
    wrAcc && busSync.rs == `SBCT_RS_LOWER |=> preload_reg[7:0] == $past(busSync.data))
    else $error("lower preload byte not stored");

  start_reload_a: assert property (
    startCmd && !timerMode |=> count_reg == $past(preload_reg)
      && state_reg == sbct_pkg::ST_COUNT)
    else $error("counter start did not reload and run");

  terminal_ready_a: assert property (
    state_reg == sbct_pkg::ST_COUNT && tick && !stopCmd && !startCmd && !timerMode
      && count_reg == 16'h0001 |=> ready_reg && count_reg == 16'h0000)
    else $error("terminal count did not set ready");

  wrap_count_a: assert property (
    state_reg == sbct_pkg::ST_COUNT && tick && !stopCmd && !startCmd && !timerMode
      && count_reg == 16'h0000 |=> count_reg == 16'hFFFF)
    else $error("counter did not wrap");

  stop_halts_a: assert property (
    stopCmd && !startCmd && state_reg == sbct_pkg::ST_COUNT && !timerMode
      |=> state_reg == sbct_pkg::ST_STOP ##1 $stable(count_reg))
    else $error("stop did not halt counter");

  stop_clears_a: assert property (
    stopCmd && !readySet |=> !ready_reg)
    else $error("stop read did not clear ready");

  timer_start_a: assert property (
    startCmd && state_reg == sbct_pkg::ST_TIMER |=> wave_reg && count_reg == $past(preload_reg))
    else $error("timer start did not raise output and reload");

  timer_toggle_a: assert property (
    state_reg == sbct_pkg::ST_TIMER && !startCmd && tick && count_reg == 16'h0001
      |=> wave_reg != $past(wave_reg) && ready_reg == ($past(ready_reg & ~stopCmd)
        | $past(half_reg)))
    else $error("timer terminal count handled wrongly");

  timer_runs_a: assert property (
    state_reg == sbct_pkg::ST_TIMER && timerMode |=> state_reg == sbct_pkg::ST_TIMER)
    else $error("timer left running state");

  irq_follow_a: assert property (
    irqN == !(ready_reg && $past(irqMask)))
    else $error("interrupt output does not follow ready bit");

  timer_wrap_c: cover property (state_reg == sbct_pkg::ST_TIMER && readySet);
  counter_tc_c: cover property (state_reg == sbct_pkg::ST_COUNT && readySet);
  stop_cmd_c: cover property (stopCmd && state_reg == sbct_pkg::ST_COUNT);
  start_cmd_c: cover property (startCmd && state_reg == sbct_pkg::ST_TIMER);

endmodule

// [tb/sbct_top_bench.sv]
// Self-checking bench for the sixteen-bit counter/timer
`include "sbct_cfg.svh"
`timescale 1ns/100ps
module sbct_top_bench;
  // --------------------------------------------------
  // Signals, clock and source pins
  // --------------------------------------------------
  typedef struct {logic [2:0] src; logic [15:0] pre; int lo; int hi;} sbct_row_type;
  localparam int LIMIT = 20000;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic csN = 1'b1;
  logic rwN = 1'b1;
  logic [3:0] rs = 4'h0;
  logic [7:0] dataIn = 8'h00;
  logic [7:0] dataOut;
  logic dataOe, dtackN, irqN, outputPinThree, baudClk, ctReadyBit;
  logic txClkA = 1'b0, txClkB = 1'b0, crystalInput = 1'b0, inputPinTwo = 1'b0;
  logic irqMask = 1'b0, op3CtSel = 1'b0, op3General = 1'b1;
  int cyc = 0;
  int ackCyc = 0;
  int n_fail = 0;
  int samples_checked = 0;
  // Timer rows give half period; counter rows a window from start to ready
  sbct_row_type rows [8] = '{
    '{3'h6, 16'h0003, 12, 12}, '{3'h7, 16'h0001, 64, 64},
    '{3'h5, 16'h0002, 52, 52}, '{3'h4, 16'h0001, 416, 416},
    '{3'h0, 16'h0008, 180, 213}, '{3'h1, 16'h0008, 26, 37},
    '{3'h2, 16'h0008, 82, 101}, '{3'h3, 16'h0008, 446, 517}};

  initial forever #50 mclk = ~mclk;

  // Cycle count and source pins: crystal and A period 4, B 12, pin two 26
  always @(posedge mclk) cyc <= cyc + 1;
  always @(posedge mclk)
  begin
    #1;
    crystalInput = (cyc % 4) < 2;
    txClkA = ((cyc + 1) % 4) < 2;
    txClkB = (cyc % 12) < 6;
    inputPinTwo = (cyc % 26) < 13;
  end

  // Hang guard
  always @(posedge mclk)
    if (cyc == LIMIT)
    begin
      n_fail++;
      tally_and_finish();
    end

  sbct_top #(.CT_WIDTH(16)) i_sbct_top (.mclk(mclk), .rstn(rstn), .csN(csN), .rwN(rwN),
    .rs(rs), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .dtackN(dtackN),
    .txClkA(txClkA), .txClkB(txClkB), .crystalInput(crystalInput),
    .inputPinTwo(inputPinTwo), .irqMask(irqMask), .op3CtSel(op3CtSel),
    .op3General(op3General), .irqN(irqN), .outputPinThree(outputPinThree),
    .baudClk(baudClk), .ctReadyBit(ctReadyBit));

  // --------------------------------------------------
  // Tasks
  // --------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic span(input string what, input int lo, input int hi, input int got);
    samples_checked++;
    if (got < lo || got > hi)
    begin
      n_fail++;
      $display("Error %s expected %0d to %0d seen %0d", what, lo, hi, got);
    end
  endtask

  // One access: hold until acknowledge, take data there, then release
  task automatic bus(input logic rw, input logic [3:0] a, input logic [7:0] d,
    output logic [7:0] q);
    csN = 1'b0;
    rwN = rw;
    rs = a;
    dataIn = d;
    while (dtackN !== 1'b0) step(1);
    q = dataOut;
    check("data enable", {15'h0000, rw}, dataOe);
    ackCyc = cyc;
    csN = 1'b1;
    while (dtackN !== 1'b1) step(1);
    step(5);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b0, a, d, q);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    bus(1'b1, a, 8'h00, q);
  endtask

  // Source, preload, then stop and start
  task automatic setup(input logic [2:0] src, input logic [15:0] p);
    logic [7:0] q;
    wr(`SBCT_RS_ACR, {1'b0, src, 4'h0});
    wr(`SBCT_RS_UPPER, p[15:8]);
    wr(`SBCT_RS_LOWER, p[7:0]);
    rd(`SBCT_RS_STOP, q);
    check("stop read data", 16'h0000, {8'h00, q});
    rd(`SBCT_RS_START, q);
  endtask

  // Cycles until the square wave next changes
  task automatic half(output int n);
    logic b;
    b = baudClk;
    n = 0;
    while (baudClk === b)
    begin
      step(1);
      n++;
    end
  endtask

  task automatic tally_and_finish();
    if (n_fail == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // --------------------------------------------------
  // Main sequence
  // --------------------------------------------------
  initial
  begin
    logic [7:0] q;
    int n;
    repeat (16) @(posedge mclk);
    #1;
    check("reset outputs", 16'h0013, {dtackN, dataOe, ctReadyBit, irqN, baudClk});
    rstn = 1'b1;
    step(2);
    check("op3 general", 16'h0001, outputPinThree);
    // Reset mode: timer from crystal, preload one
    rd(`SBCT_RS_START, q);
    half(n);
    half(n);
    span("reset half period", 4, 4, n);
    // Table of sources and preloads
    foreach (rows[i])
    begin
      setup(rows[i].src, rows[i].pre);
      if (rows[i].src[2])
      begin
        half(n);
        half(n);
        span("half period", rows[i].lo, rows[i].hi, n);
      end
      else
      begin
        while (ctReadyBit !== 1'b1) step(1);
        span("count time", rows[i].lo, rows[i].hi, cyc - ackCyc);
      end
    end
    // Timer: restart from low output, ready every second terminal count
    irqMask = 1'b1;
    setup(3'h6, 16'h0008);
    op3CtSel = 1'b1;
    while (baudClk !== 1'b0) step(1);
    rd(`SBCT_RS_START, q);
    check("start output", 16'h0001, baudClk);
    half(n);
    check("ready first", 16'h0000, ctReadyBit);
    half(n);
    span("timer half", 32, 32, n);
    step(2);
    check("ready second", 16'h0002, {ctReadyBit, irqN});
    check("op3 wave", 16'h0003, {baudClk, outputPinThree});
    rd(`SBCT_RS_ISR, q);
    check("status bit", 16'h0001, q[`SBCT_ISR_RDY_BIT]);
    rd(`SBCT_RS_STOP, q);
    check("stop ready", 16'h0000, ctReadyBit);
    step(2);
    check("irq release", 16'h0001, irqN);
    half(n);
    half(n);
    span("still running", 32, 32, n);
    // New preload waits for the next reload
    wr(`SBCT_RS_LOWER, 8'h04);
    half(n);
    half(n);
    span("new preload", 16, 16, n);
    // Counter wraps below zero, stop halts it
    setup(3'h1, 16'h0001);
    while (ctReadyBit !== 1'b1) step(1);
    wr(`SBCT_RS_LOWER, 8'h50);
    rd(`SBCT_RS_STOP, q);
    check("counter stop", 16'h0001, {ctReadyBit, outputPinThree});
    step(1100);
    rd(`SBCT_RS_UPPER, q);
    check("count upper", 16'h00FF, {8'h00, q});
    rd(`SBCT_RS_LOWER, q);
    span("count lower", 250, 253, q);
    rd(4'h0, q);
    check("unmapped read", 16'h0000, {8'h00, q});
    rd(`SBCT_RS_ACR, q);
    check("control read", 16'h0000, {8'h00, q});
    // Mid-run reset returns to timer mode from the crystal, preload one
    rstn = 1'b0;
    step(3);
    check("reset again", 16'h0013, {dtackN, dataOe, ctReadyBit, irqN, baudClk});
    rstn = 1'b1;
    step(2);
    rd(`SBCT_RS_START, q);
    half(n);
    half(n);
    span("reset mode again", 4, 4, n);
    tally_and_finish();
  end
endmodule
